// >>> src/tcc_consts.svh
// offsets, field positions, reset values and timing counts of the control block
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// ****************************************
// register map (byte addresses = index*4)
// ****************************************
`define TCC_IDX_CTRL       8'h0d
`define TCC_IDX_DXTIME     8'h0a
`define TCC_IDX_REPLYDLY   8'h1a
`define TCC_IDX_STATUS     8'h0f
`define TCC_IDX_TXCFG      8'h20
`define TCC_IDX_SYSTIME    8'h06

// ****************************************
// control bit positions
// ****************************************
`define TCC_B_SUPPRESS     0
`define TCC_B_GO           1
`define TCC_B_SCHED_TX     2
`define TCC_B_CANCEL       3
`define TCC_B_IDLE         6
`define TCC_B_AWAIT        7
`define TCC_B_RXON         8
`define TCC_B_SCHED_RX     9
`define TCC_B_TOGGLE       24

// ****************************************
// status bit positions
// ****************************************
`define TCC_S_TXBUSY       0
`define TCC_S_RXON         1
`define TCC_S_BUFERR       2
`define TCC_S_HALF         3
`define TCC_S_FCSOK        4
`define TCC_S_RXWAIT       5

`define TCC_CTRL_WMASK     32'h0100_03cf
`define TCC_CTRL_RESET     32'h0000_0000

// ****************************************
// timing
// ****************************************
`define TCC_CLK_MHZ        40
`define TCC_RX_STARTUP_US  16
`define TCC_RX_STARTUP_CYC (`TCC_RX_STARTUP_US * `TCC_CLK_MHZ)

`endif

// >>> src/tcc_pkg.sv
// types of the transceiver control block
package tcc_pkg;
  typedef enum logic [2:0] {
    TCC_IDLE   = 3'b000,
    TCC_TX     = 3'b001,
    TCC_TXWAIT = 3'b010,
    TCC_TURN   = 3'b011,
    TCC_RXWAIT = 3'b100,
    TCC_RXUP   = 3'b101,
    TCC_RX     = 3'b110
  } tcc_state_type;
endpackage

// >>> src/tcc_ctrl.sv
// transceiver system control command interpreter with ahb-lite register slave
`timescale 1ns/1ps
`include "tcc_consts.svh"
// Behaviour
// - suppress bit sends buffer bytes, no checksum
// - transmit command in idle starts at once, or at programmed time with scheduled tx bit
// - cancel re-enables checksum for current frame
// - late buffer write ignores cancel, bad checksum
// - late write sets buffer error status flag
// - cancel bit self-clears once acted on
// - off command returns to idle, aborts all
// - off bit self-clears once idle
// - await reply turns receiver on after frame
// - turnaround waits programmed reply delay
// - await bit clears at rx on or off
// - receiver-on starts search, bit self-clears
// - receiver waits 16 us startup delay
// - scheduled rx ready at programmed time
// - toggle switches host half, status reports it
module tcc_ctrl #(
  parameter int unsigned RX_STARTUP = `TCC_RX_STARTUP_CYC,
  parameter int unsigned LEN_W      = 10
) (
  // ahb-lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // transmit buffer side
  input  wire logic             txbuf_wr,
  input  wire logic [LEN_W-1:0] txbuf_wr_addr,
  input  wire logic             tx_byte_done,
  input  wire logic             tx_frame_done,
  // radio controls
  output logic             tx_enable,
  output logic             tx_send_fcs,
  output logic             rx_enable,
  output logic             rx_sampling,
  output logic             rx_half_sel
);
  import tcc_pkg::*;

  // ****************************************
  // registers and bus phase
  // ****************************************
  tcc_state_type    state_reg;
  logic [31:0]      scheduled_event_time_reg;
  logic [31:0]      reply_dly_reg;
  logic [31:0]      system_time_counter_reg;
  logic [LEN_W-1:0] tx_offs_reg;
  logic [LEN_W-1:0] tx_ptr_reg;
  logic [31:0]      cnt_reg;
  logic             suppress_reg;
  logic             await_reg;
  logic             sched_tx_reg;
  logic             sched_rx_reg;
  logic             buf_err_reg;
  logic             wr_pend_reg;
  logic [7:0]       addr_reg;
  logic [31:0]      wdat;
  logic             ctrl_wr;
  logic             acc_ok;

  assign wdat    = hwdata;
  assign acc_ok  = hsel && htrans[1] && hready;
  assign ctrl_wr = wr_pend_reg && (addr_reg == `TCC_IDX_CTRL);

  function automatic logic wr_to(input logic [7:0] idx);
    return wr_pend_reg && (addr_reg == idx);
  endfunction

  // ****************************************
  // readback words
  // ****************************************
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;

  // command bits read back as zero; pending state and the held suppress bit are visible
  always_comb begin
    ctrl_rd                  = 32'h0000_0000;
    ctrl_rd[`TCC_B_SUPPRESS] = suppress_reg;
    ctrl_rd[`TCC_B_SCHED_TX] = sched_tx_reg;
    ctrl_rd[`TCC_B_AWAIT]    = await_reg;
    ctrl_rd[`TCC_B_RXON]     = (state_reg == TCC_RXWAIT);
    ctrl_rd[`TCC_B_SCHED_RX] = sched_rx_reg;
  end

  always_comb begin
    stat_rd                  = 32'h0000_0000;
    stat_rd[`TCC_S_TXBUSY]   = tx_enable;
    stat_rd[`TCC_S_RXON]     = rx_enable;
    stat_rd[`TCC_S_BUFERR]   = buf_err_reg;
    stat_rd[`TCC_S_HALF]     = rx_half_sel;
    stat_rd[`TCC_S_FCSOK]    = tx_send_fcs;
    stat_rd[`TCC_S_RXWAIT]   = (state_reg == TCC_RXWAIT);
  end

  // zero-wait slave, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      wr_pend_reg <= acc_ok && hwrite;
      if (acc_ok) begin
        addr_reg <= haddr[9:2];
      end
    end
  end

  // read data registered in address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc_ok && !hwrite) begin
      unique case (haddr[9:2])
        `TCC_IDX_CTRL:     hrdata <= ctrl_rd;
        `TCC_IDX_DXTIME:   hrdata <= scheduled_event_time_reg;
        `TCC_IDX_REPLYDLY: hrdata <= reply_dly_reg;
        `TCC_IDX_SYSTIME:  hrdata <= system_time_counter_reg;
        `TCC_IDX_TXCFG:    hrdata <= {{(32-LEN_W){1'b0}}, tx_offs_reg};
        `TCC_IDX_STATUS:   hrdata <= stat_rd;
        default:           hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // plain data registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scheduled_event_time_reg   <= 32'h0000_0000;
      reply_dly_reg <= 32'h0000_0000;
      tx_offs_reg   <= '0;
    end else begin
      if (wr_to(`TCC_IDX_DXTIME)) begin
        scheduled_event_time_reg <= wdat;
      end
      if (wr_to(`TCC_IDX_REPLYDLY)) begin
        reply_dly_reg <= wdat;
      end
      if (wr_to(`TCC_IDX_TXCFG)) begin
        tx_offs_reg <= wdat[LEN_W-1:0];
      end
    end
  end

  // free-running device time base
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      system_time_counter_reg <= 32'h0000_0000;
    end else begin
      system_time_counter_reg <= system_time_counter_reg + 32'h0000_0001;
    end
  end

  // ****************************************
  // command sequencer
  // ****************************************
  logic cmd_off;
  logic cmd_go;
  logic cmd_rx;
  logic time_hit;
  logic [31:0] rx_lead;
  logic rx_lead_hit;
  logic go_start;

  assign cmd_off  = ctrl_wr && wdat[`TCC_B_IDLE];
  assign cmd_go   = ctrl_wr && wdat[`TCC_B_GO] && !cmd_off;
  assign cmd_rx   = ctrl_wr && wdat[`TCC_B_RXON] && !cmd_off;
  // start early by the startup delay so preamble arrives on time
  assign rx_lead  = scheduled_event_time_reg - 32'(RX_STARTUP);
  assign time_hit = (system_time_counter_reg == scheduled_event_time_reg);
  assign rx_lead_hit = (system_time_counter_reg == rx_lead);
  assign go_start = cmd_go && (state_reg == TCC_IDLE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= TCC_IDLE;
      cnt_reg   <= 32'h0000_0000;
    end else if (cmd_off) begin
      state_reg <= TCC_IDLE;
    end else begin
      unique case (state_reg)
        TCC_IDLE: begin
          if (cmd_go) begin
            state_reg <= wdat[`TCC_B_SCHED_TX] ? TCC_TXWAIT : TCC_TX;
          end else if (cmd_rx) begin
            state_reg <= wdat[`TCC_B_SCHED_RX] ? TCC_RXWAIT : TCC_RXUP;
            cnt_reg   <= 32'(RX_STARTUP) - 32'h0000_0001;
          end
        end
        TCC_TXWAIT: begin
          if (time_hit) begin
            state_reg <= TCC_TX;
          end
        end
        TCC_TX: begin
          if (tx_frame_done) begin
            state_reg <= await_reg ? TCC_TURN : TCC_IDLE;
            cnt_reg   <= reply_dly_reg;
          end
        end
        TCC_TURN: begin
          if (cnt_reg == 32'h0000_0000) begin
            state_reg <= TCC_RXUP;
            cnt_reg   <= 32'(RX_STARTUP) - 32'h0000_0001;
          end else begin
            cnt_reg <= cnt_reg - 32'h0000_0001;
          end
        end
        TCC_RXWAIT: begin
          if (rx_lead_hit) begin
            state_reg <= TCC_RXUP;
            cnt_reg   <= 32'(RX_STARTUP) - 32'h0000_0001;
          end
        end
        TCC_RXUP: begin
          if (cnt_reg == 32'h0000_0000) begin
            state_reg <= TCC_RX;
          end else begin
            cnt_reg <= cnt_reg - 32'h0000_0001;
          end
        end
        TCC_RX: begin
          state_reg <= TCC_RX;
        end
        default: begin
          state_reg <= TCC_IDLE;
        end
      endcase
    end
  end

  // command flags held while their action is pending
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      await_reg    <= 1'b0;
      sched_tx_reg <= 1'b0;
      sched_rx_reg <= 1'b0;
    end else if (cmd_off) begin
      await_reg    <= 1'b0;
      sched_tx_reg <= 1'b0;
      sched_rx_reg <= 1'b0;
    end else begin
      if (go_start) begin
        await_reg    <= wdat[`TCC_B_AWAIT];
        sched_tx_reg <= wdat[`TCC_B_SCHED_TX];
      end else if (state_reg == TCC_TXWAIT && time_hit) begin
        sched_tx_reg <= 1'b0;
      end
      if (state_reg == TCC_TURN && cnt_reg == 32'h0000_0000) begin
        await_reg <= 1'b0;
      end
      if (cmd_rx && state_reg == TCC_IDLE) begin
        sched_rx_reg <= wdat[`TCC_B_SCHED_RX];
      end else if (state_reg == TCC_RXWAIT && rx_lead_hit) begin
        sched_rx_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // checksum suppression and late writes
  // ****************************************
  logic late_wr;

  // write lands in the region already fetched for sending
  assign late_wr = txbuf_wr && (state_reg == TCC_TX) &&
                   (txbuf_wr_addr >= tx_offs_reg) && (txbuf_wr_addr < tx_ptr_reg);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_ptr_reg <= '0;
    end else if (state_reg != TCC_TX) begin
      tx_ptr_reg <= tx_offs_reg;
    end else if (tx_byte_done) begin
      tx_ptr_reg <= tx_ptr_reg + LEN_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      suppress_reg <= 1'b0;
    end else if (go_start) begin
      suppress_reg <= wdat[`TCC_B_SUPPRESS];
    end else if (ctrl_wr && wdat[`TCC_B_CANCEL] && state_reg == TCC_TX &&
                 !buf_err_reg && !late_wr) begin
      suppress_reg <= 1'b0;
    end
  end

  // sticky error; a new frame start clears it, but a late write in that cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_err_reg <= 1'b0;
    end else if (late_wr) begin
      buf_err_reg <= 1'b1;
    end else if (go_start) begin
      buf_err_reg <= 1'b0;
    end
  end

  // ****************************************
  // receive half toggle and outputs
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_half_sel <= 1'b0;
    end else if (ctrl_wr && wdat[`TCC_B_TOGGLE]) begin
      rx_half_sel <= ~rx_half_sel;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_enable   <= 1'b0;
      tx_send_fcs <= 1'b0;
      rx_enable   <= 1'b0;
      rx_sampling <= 1'b0;
    end else begin
      tx_enable   <= (state_reg == TCC_TX) && !cmd_off && !tx_frame_done;
      tx_send_fcs <= !suppress_reg;
      rx_enable   <= ((state_reg == TCC_RXUP) || (state_reg == TCC_RX)) && !cmd_off;
      rx_sampling <= (state_reg == TCC_RX) && !cmd_off;
    end
  end
endmodule

// >>> test/tcc_ctrl_properties.sv
// checker on the control block ports
`timescale 1ns/1ps
module tcc_ctrl_properties #(
  parameter int unsigned RX_STARTUP = 640
) (
  // watched ports
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        tx_frame_done,
  input wire logic        tx_enable,
  input wire logic        tx_send_fcs,
  input wire logic        rx_enable,
  input wire logic        rx_sampling,
  input wire logic        rx_half_sel
);
  logic       wq;
  logic       idle;
  logic [9:0] cnt;
  assign idle = !tx_enable && !rx_enable;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // high in the data phase of a control write
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) wq <= 1'b0;
    else if (hready) wq <= hsel && htrans[1] && hwrite && haddr == 32'h34;
  // receiver start-up length, cleared while off
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) cnt <= 10'h0;
    else cnt <= (rx_enable && !rx_sampling) ? cnt + 10'h1 : 10'h0;
  property p_bus;
    hreadyout && !hresp;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer not okay");
  property p_go;
    wq && hwdata[1] && !hwdata[2] && !hwdata[6] && idle
      |-> ##2 tx_enable && tx_send_fcs != $past(hwdata[0], 2);
  endproperty
  a_go: assert property (p_go) else $error("send start wrong");
  property p_off;
    wq && hwdata[6] |-> ##3 !tx_enable && !rx_enable && !rx_sampling;
  endproperty
  a_off: assert property (p_off) else $error("off not idle");
  property p_prio;
    wq && hwdata[6] && !tx_enable |=> !tx_enable [*4];
  endproperty
  a_prio: assert property (p_prio) else $error("send despite off");
  property p_frame;
    tx_enable && tx_frame_done |=> !tx_enable;
  endproperty
  a_frame: assert property (p_frame) else $error("sender stays on");
  property p_inen;
    rx_sampling |-> rx_enable;
  endproperty
  a_inen: assert property (p_inen) else $error("search while off");
  property p_startup;
    $rose(rx_sampling) |-> cnt >= 10'(RX_STARTUP - 1) && cnt <= 10'(RX_STARTUP + 1);
  endproperty
  a_startup: assert property (p_startup) else $error("start-up length");
  property p_toggle;
    wq && hwdata[24] |=> rx_half_sel != $past(rx_half_sel);
  endproperty
  a_toggle: assert property (p_toggle) else $error("half not toggled");
endmodule
bind tcc_ctrl tcc_ctrl_properties #(.RX_STARTUP(RX_STARTUP)) i_tcc_ctrl_properties (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .tx_frame_done(tx_frame_done), .tx_enable(tx_enable),
  .tx_send_fcs(tx_send_fcs), .rx_enable(rx_enable), .rx_sampling(rx_sampling),
  .rx_half_sel(rx_half_sel));

// >>> test/tcc_radio_model.sv
// radio datapath model: fetches frame bytes while sending
`timescale 1ns/1ps
module tcc_radio_model #(
  parameter int unsigned NBYTES = 6
) (
  // clock, reset, pacing
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic slow,
  // radio side
  input  wire logic tx_enable,
  output logic      tx_byte_done,
  output logic      tx_frame_done
);
  logic [3:0] gap_reg;
  logic [3:0] cnt_reg;
  // an abort drops the count so the next frame starts clean
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {gap_reg, cnt_reg, tx_byte_done, tx_frame_done} <= 10'h0;
    end else if (!tx_enable || gap_reg != 4'h0) begin
      gap_reg <= tx_enable ? gap_reg - 4'h1 : 4'h0;
      cnt_reg <= tx_enable ? cnt_reg : 4'h0;
      {tx_byte_done, tx_frame_done} <= 2'b00;
    end else begin
      tx_byte_done <= cnt_reg < NBYTES;
      tx_frame_done <= cnt_reg == NBYTES;
      cnt_reg <= cnt_reg + 4'h1;
      gap_reg <= slow ? 4'h7 : 4'h1;
    end
  end
endmodule

// >>> test/tb_top.sv
// self-checking bench for the control block
`timescale 1ns/1ps
module tb_top;
  typedef struct {string n; logic [31:0] e; logic [31:0] m;} tcc_exp_type;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        txw_en = 1'b0;
  logic        slow = 1'b1;
  logic        rd_dp = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [9:0]  txw_a = 10'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] seed = 32'hdddf;
  logic [31:0] cyc = 32'h0;
  logic [31:0] hrdata;
  logic        hready, hresp, byte_d, frame_d, tx_en, fcs, rx_en, rx_smp, half;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          n;
  int          d;
  tcc_exp_type q[$];
  tcc_exp_type e;
  wire [5:0]   ev = {hready, byte_d, rx_smp, rx_en, !tx_en, tx_en};
  tcc_ctrl #(.RX_STARTUP(8)) i_tcc_ctrl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .txbuf_wr(txw_en), .txbuf_wr_addr(txw_a),
    .tx_byte_done(byte_d), .tx_frame_done(frame_d), .tx_enable(tx_en),
    .tx_send_fcs(fcs), .rx_enable(rx_en), .rx_sampling(rx_smp), .rx_half_sel(half));
  tcc_radio_model i_tcc_radio_model (.hclk(hclk), .hresetn(hresetn), .slow(slow),
    .tx_enable(tx_en), .tx_byte_done(byte_d), .tx_frame_done(frame_d));
  initial forever #12.5 hclk = ~hclk;
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic ck(input logic [31:0] seen, input logic [31:0] ex, input string nm);
    cmp_count++;
    if (seen !== ex) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // bounded wait on one event, cycles counted in c
  task automatic wt(input int k, output int c);
    for (c = 1; c < 3000; c++) begin
      @(posedge hclk);
      if (ev[k] === 1'b1) return;
    end
    num_errors++;
    wrap_up();
  endtask
  // reserved bits always go out as zero
  task automatic wr(input logic w, input logic [31:0] a, input logic [31:0] dat);
    int c;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wt(5, c);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= dat;
    wt(5, c);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] ex, input logic [31:0] m,
                    input string nm);
    q.push_back('{nm, ex & m, m});
    wr(1'b0, a, 32'h0);
  endtask
  task automatic txw(input logic [9:0] a);
    txw_en <= 1'b1;
    txw_a <= a;
    @(posedge hclk);
    txw_en <= 1'b0;
  endtask
  // read data are taken at the end of the data phase
  always @(posedge hclk) begin
    if (rd_dp && q.size() > 0) begin
      e = q.pop_front();
      ck(hrdata & e.m, e.e, e.n);
    end
    rd_dp <= hsel && htrans[1] && !hwrite && hready;
  end
  // mirrors the device time base, which runs from reset release
  always @(posedge hclk) begin
    if (hresetn) cyc <= cyc + 32'h1;
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd(32'h34, 32'h0, 32'hffff_ffff, "ctrl reset");
    rd(32'h3f0, 32'h0, 32'hffff_ffff, "unmapped");
    wr(1'b1, 32'h80, 32'h0);
    wr(1'b1, 32'h34, 32'h3);
    wt(0, n);
    ck({31'h0, fcs}, 32'h0, "fcs off");
    txw(10'h10 + 10'(rnd() % 32'd900));
    wr(1'b1, 32'h34, 32'h8);
    repeat (3) @(posedge hclk);
    ck({31'h0, fcs}, 32'h1, "fcs back");
    rd(32'h34, 32'h0, 32'h8, "cancel bit");
    wt(1, n);
    $display("test cancel done");
    wr(1'b1, 32'h34, 32'h3);
    wt(4, n);
    wt(4, n);
    txw(10'(rnd() % 32'd2));
    wr(1'b1, 32'h34, 32'h8);
    repeat (3) @(posedge hclk);
    ck({31'h0, fcs}, 32'h0, "fcs late");
    rd(32'h3c, 32'h4, 32'h4, "late flag");
    wt(1, n);
    $display("test late write done");
    slow <= 1'b0;
    d = 2 + int'(rnd() % 32'd16);
    wr(1'b1, 32'h68, 32'(d));
    wr(1'b1, 32'h34, 32'h82);
    wt(0, n);
    wt(1, n);
    wt(2, n);
    ck({31'h0, n >= d - 1 && n <= d + 2}, 32'h1, "reply delay");
    rd(32'h34, 32'h0, 32'h80, "await bit");
    wt(3, n);
    wr(1'b1, 32'h34, 32'h42);
    repeat (3) @(posedge hclk);
    ck({29'h0, tx_en, rx_en, rx_smp}, 32'h0, "off");
    rd(32'h34, 32'h0, 32'h42, "off bit");
    wr(1'b1, 32'h34, 32'h82);
    wt(0, n);
    rd(32'h34, 32'h80, 32'h80, "await held");
    wr(1'b1, 32'h34, 32'h40);
    rd(32'h34, 32'h0, 32'h80, "await off");
    $display("test turnaround done");
    wr(1'b1, 32'h34, 32'h100);
    wt(3, n);
    ck({31'h0, n >= 8 && n <= 12}, 32'h1, "start-up");
    rd(32'h34, 32'h0, 32'h100, "rx on bit");
    rd(32'h3c, 32'h2, 32'h2, "rx on flag");
    wr(1'b1, 32'h34, 32'h40);
    $display("test receive done");
    for (int k = 1; k >= 0; k--) begin
      wr(1'b1, 32'h34, 32'h0100_0000);
      rd(32'h3c, {28'h0, k[0], 3'h0}, 32'h8, "half flag");
      ck({31'h0, half}, {31'h0, k[0]}, "half pin");
    end
    $display("test toggle done");
    d = int'(cyc) + 40;
    wr(1'b1, 32'h28, 32'(d));
    wr(1'b1, 32'h34, 32'h6);
    rd(32'h34, 32'h4, 32'h4, "tx sched bit");
    ck({31'h0, tx_en}, 32'h0, "tx held");
    wt(0, n);
    ck({31'h0, cyc >= 32'(d) && cyc <= 32'(d + 3)}, 32'h1, "tx time");
    wt(1, n);
    d = int'(cyc) + 60;
    wr(1'b1, 32'h28, 32'(d));
    wr(1'b1, 32'h34, 32'h300);
    rd(32'h34, 32'h300, 32'h300, "rx sched bits");
    wt(3, n);
    ck({31'h0, cyc >= 32'(d) && cyc <= 32'(d + 3)}, 32'h1, "rx time");
    wr(1'b1, 32'h34, 32'h40);
    $display("test scheduled done");
    repeat (4) @(posedge hclk);
    wrap_up();
  end
endmodule
